//--- src/rxsed_pkg.sv
// package: constants for the receive signal strength and energy readout
package rxsed_pkg;
    // register port offsets
    localparam logic [5:0] RXSED_ADDR_LINK_QUALITY = 6'h06;
    localparam logic [5:0] RXSED_ADDR_ENERGY = 6'h07;
    // field positions in the link quality status register
    localparam int RXSED_CRC_BIT = 7;
    localparam int RXSED_RANDOM_LSB = 5;
    localparam int RXSED_STRENGTH_MSB = 4;
    // values after reset and value ranges
    localparam logic [7:0] RXSED_ENERGY_RESET = 8'hFF;
    localparam logic [7:0] RXSED_ENERGY_MAX = 8'h54;
    localparam logic [4:0] RXSED_STRENGTH_MAX = 5'h1C;
    localparam logic [4:0] RXSED_STRENGTH_STEP_DB = 5'h03;
    // timing, printed figures and derived cycle counts
    localparam int RXSED_CLK_PERIOD_NS = 100;
    localparam int RXSED_REFRESH_NS = 2000;
    localparam int RXSED_ED_BASE_US = 128;
    localparam int RXSED_ED_FAST_US = 32;
    localparam int RXSED_ED_RESULT_US = 140;
    localparam int RXSED_REFRESH_CYC = RXSED_REFRESH_NS / RXSED_CLK_PERIOD_NS;
    localparam int RXSED_BASE_CYC = (RXSED_ED_BASE_US * 1000) / RXSED_CLK_PERIOD_NS;
    localparam int RXSED_FAST_CYC = (RXSED_ED_FAST_US * 1000) / RXSED_CLK_PERIOD_NS;
    localparam int RXSED_RESULT_CYC =
        (RXSED_ED_RESULT_US * 1000 + RXSED_CLK_PERIOD_NS - 1) / RXSED_CLK_PERIOD_NS;
    // samples per window give the averaging shift
    localparam int RXSED_BASE_SHIFT = 6;
    localparam int RXSED_FAST_SHIFT = 4;
    localparam int RXSED_ACC_W = 13;
    localparam int RXSED_CNT_W = 11;
    // measurement sequencer states
    typedef enum logic [2:0] {
        RXSED_IDLE = 3'b001,
        RXSED_MEASURE = 3'b010,
        RXSED_PROCESS = 3'b100
    } rxsed_state_type;
endpackage

//--- src/rxsed_strength_sampler.sv
// module: periodic signal strength sampler with clamping
`timescale 1ns/100ps
module rxsed_strength_sampler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_receive,
    input wire logic [4:0] strength_raw,
    output logic [4:0] signal_strength,
    output logic sample_tick
);
    import rxsed_pkg::*;

    typedef struct packed {
        logic [4:0] tick_cnt;
        logic [4:0] strength;
        logic tick;
    } rxsed_smp_type;

    rxsed_smp_type s_q, s_d;

    // free running refresh timer; value only taken while receiving
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == 5'(RXSED_REFRESH_CYC - 1)) begin
            s_d.tick_cnt = 5'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 5'h01;
        end
        // clamp so the field never leaves its legal range
        if (s_d.tick && in_receive) begin
            s_d.strength = (strength_raw > RXSED_STRENGTH_MAX) ? RXSED_STRENGTH_MAX
                                                                : strength_raw;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign signal_strength = s_q.strength;
    assign sample_tick = s_q.tick;

    // ********************************************************************
    // checks
    // ********************************************************************
    chk_strength_legal: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.strength <= RXSED_STRENGTH_MAX)
        else $error("strength above legal range");
    // a new value shows in the cycle that carries the tick, taken while receiving
    chk_strength_refresh: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.strength != $past(s_q.strength) |-> s_q.tick && $past(in_receive))
        else $error("strength changed off the refresh tick");
endmodule

//--- src/rxsed_readout.sv
// module: receive signal strength, checksum flag and energy detection readout
`timescale 1ns/100ps
module rxsed_readout (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic state_listening,
    input wire logic state_receiving,
    input wire logic high_rate,
    input wire logic frame_end_irq,
    input wire logic crc_ok,
    input wire logic sync_header_found,
    input wire logic [4:0] strength_raw,
    input wire logic [1:0] random_bits,
    output logic [4:0] signal_strength,
    output logic measure_done_irq
);
    import rxsed_pkg::*;

    typedef struct packed {
        rxsed_state_type fsm;
        logic [RXSED_CNT_W-1:0] cnt;
        logic [RXSED_CNT_W-1:0] win_len;
        logic [RXSED_ACC_W-1:0] acc;
        logic fast;
        logic manual;
        logic [7:0] energy_result;
        logic crc_valid;
        logic done;
        logic [7:0] rdata;
    } rxsed_main_type;

    rxsed_main_type r_q, r_d;
    logic in_receive;
    logic sample_tick;
    logic manual_req;
    logic start_meas;
    logic result_load;
    logic [RXSED_ACC_W-1:0] avg;
    logic [7:0] sample_db;

    // ********************************************************************
    // strength sampling
    // ********************************************************************
    assign in_receive = state_listening | state_receiving;

    rxsed_strength_sampler u_sampler (
        .clk(clk),
        .rst_n(rst_n),
        .in_receive(in_receive),
        .strength_raw(strength_raw),
        .signal_strength(signal_strength),
        .sample_tick(sample_tick)
    );

    // ********************************************************************
    // measurement sequencer
    // ********************************************************************
    // request decode; the written data is never stored
    assign manual_req = reg_wr && (reg_addr == RXSED_ADDR_ENERGY);
    assign start_meas = (manual_req && in_receive) || sync_header_found;
    assign result_load = (r_q.fsm == RXSED_PROCESS)
                         && (r_q.cnt == RXSED_CNT_W'(RXSED_RESULT_CYC - 1));
    // each sample converts to dB above floor: 0 stays 0, else 3*(v-1)
    assign sample_db = (signal_strength == 5'h00) ? 8'h00
                       : 8'(RXSED_STRENGTH_STEP_DB) * 8'(signal_strength - 5'h01);
    // window sample count is a power of two, so the average is a shift
    assign avg = r_q.fast ? (r_q.acc >> RXSED_FAST_SHIFT) : (r_q.acc >> RXSED_BASE_SHIFT);

    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        // checksum flag follows each frame end event only
        if (frame_end_irq) begin
            r_d.crc_valid = crc_ok;
        end
        unique case (r_q.fsm)
            RXSED_IDLE: begin
            end
            RXSED_MEASURE: begin
                r_d.cnt = r_q.cnt + RXSED_CNT_W'(1);
                if (sample_tick) begin
                    r_d.acc = r_q.acc + RXSED_ACC_W'(sample_db);
                end
                if (r_q.cnt == r_q.win_len - RXSED_CNT_W'(1)) begin
                    r_d.fsm = RXSED_PROCESS;
                end
            end
            RXSED_PROCESS: begin
                r_d.cnt = r_q.cnt + RXSED_CNT_W'(1);
                if (result_load) begin
                    // clamp keeps the result inside 0x00..0x54
                    r_d.energy_result = (avg > RXSED_ACC_W'(RXSED_ENERGY_MAX))
                                        ? RXSED_ENERGY_MAX : avg[7:0];
                    r_d.done = r_q.manual;
                    r_d.fsm = RXSED_IDLE;
                end
            end
        endcase
        // a new request restarts the window; the older one is dropped unless it loads its result in that same cycle
        if (start_meas) begin
            r_d.fsm = RXSED_MEASURE;
            r_d.cnt = '0;
            r_d.acc = '0;
            r_d.manual = manual_req && in_receive;
            // manual requests keep the long window even at high rate
            r_d.fast = high_rate && !(manual_req && in_receive);
            r_d.win_len = r_d.fast ? RXSED_CNT_W'(RXSED_FAST_CYC)
                                   : RXSED_CNT_W'(RXSED_BASE_CYC);
        end
        // outside receive states only the completion event is given
        if (manual_req && !in_receive) begin
            r_d.done = 1'b1;
        end
        // read data is captured so the answer comes from a flip-flop
        if (reg_rd) begin
            if (reg_addr == RXSED_ADDR_LINK_QUALITY) begin
                r_d.rdata = {r_q.crc_valid, random_bits, signal_strength};
            end else if (reg_addr == RXSED_ADDR_ENERGY) begin
                r_d.rdata = r_q.energy_result;
            end else begin
                r_d.rdata = 8'h00;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
            r_q.fsm <= RXSED_IDLE;
            r_q.energy_result <= RXSED_ENERGY_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    assign reg_rdata = r_q.rdata;
    assign measure_done_irq = r_q.done;

    // ********************************************************************
    // checks
    // ********************************************************************
    chk_crc_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !frame_end_irq |=> r_q.crc_valid == $past(r_q.crc_valid))
        else $error("checksum flag changed without frame end");
    chk_crc_update: assert property (@(posedge clk) disable iff (!rst_n)
        frame_end_irq |=> r_q.crc_valid == $past(crc_ok))
        else $error("checksum flag not taken on frame end");
    chk_result_range: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.energy_result <= RXSED_ENERGY_MAX || r_q.energy_result == RXSED_ENERGY_RESET)
        else $error("energy result outside legal values");
    chk_result_time: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.energy_result != $past(r_q.energy_result)
        |-> $past(r_q.fsm == RXSED_PROCESS && r_q.cnt == RXSED_CNT_W'(RXSED_RESULT_CYC - 1)))
        else $error("energy result written at wrong moment");
    // the rate select is judged as it stood at the starting edge
    chk_window_len: assert property (@(posedge clk) disable iff (!rst_n)
        start_meas |=> r_q.win_len == (($past(high_rate) && !r_q.manual)
            ? RXSED_CNT_W'(RXSED_FAST_CYC) : RXSED_CNT_W'(RXSED_BASE_CYC)))
        else $error("measurement window length wrong");
    chk_done_cause: assert property (@(posedge clk) disable iff (!rst_n)
        measure_done_irq |-> $past((result_load && r_q.manual) || (manual_req && !in_receive)))
        else $error("done event without manual cause");
    chk_manual_done: assert property (@(posedge clk) disable iff (!rst_n)
        result_load && r_q.manual && !start_meas |=> measure_done_irq)
        else $error("manual measurement ended without done");
    // a refused request may not start a window; one already running carries on
    chk_idle_request: assert property (@(posedge clk) disable iff (!rst_n)
        manual_req && !in_receive && !sync_header_found
        |=> measure_done_irq
            && ($past(r_q.fsm) != RXSED_IDLE || r_q.fsm == RXSED_IDLE))
        else $error("request outside receive mishandled");
    chk_write_discard: assert property (@(posedge clk) disable iff (!rst_n)
        manual_req && !result_load |=> r_q.energy_result == $past(r_q.energy_result))
        else $error("written data reached energy result");
    chk_measure_start: assert property (@(posedge clk) disable iff (!rst_n)
        manual_req && in_receive |=> r_q.fsm == RXSED_MEASURE && r_q.cnt == '0)
        else $error("manual request did not start measurement");
endmodule

//--- sim/rxsed_host_model.sv
// host model: register port master that reads and starts measurements
`timescale 1ns/100ps
module rxsed_host_model (
    input wire logic clk,
    output logic [5:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    // idle port at time zero
    initial begin
        reg_addr = 6'h3F;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // one strobe cycle per access; a start write goes out whether or not a receive state is active
    // no frame start event is ever used as a timing reference for reads
    task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = wr;
        reg_rd = ~wr;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // scramble released lines so a stale value never passes for a hold
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask
endmodule

//--- sim/tb_rx_signal_energy_readout.sv
// testbench: strength, checksum flag and energy result through the register port
`timescale 1ns/100ps
module tb_rx_signal_energy_readout;
    import rxsed_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd_d = 1'b0;
    logic [5:0] reg_addr;
    logic reg_wr, reg_rd;
    logic [7:0] reg_wdata, reg_rdata;
    logic state_listening = 1'b0, state_receiving = 1'b0, high_rate = 1'b0;
    logic frame_end_irq = 1'b0, crc_ok = 1'b0, sync_header_found = 1'b0;
    logic [4:0] strength_raw = 5'h00, signal_strength;
    logic [1:0] random_bits = 2'h0;
    logic measure_done_irq;
    logic [7:0] exp_q[$];
    int n_mismatch = 0, checks_done = 0;
    always #50 clk = ~clk;
    rxsed_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    rxsed_readout dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .state_listening(state_listening), .state_receiving(state_receiving),
        .high_rate(high_rate), .frame_end_irq(frame_end_irq), .crc_ok(crc_ok),
        .sync_header_found(sync_header_found), .strength_raw(strength_raw),
        .random_bits(random_bits), .signal_strength(signal_strength),
        .measure_done_irq(measure_done_irq));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(logic [5:0] addr, logic [7:0] exp);
        exp_q.push_back(exp);
        host.access(1'b0, addr, 8'h00);
    endtask
    // count edges after the taking edge until the done pulse; a pulse that
    // already stands counts as zero; bounded so a lost pulse cannot hang
    task automatic wait_done(output int n);
        n = 0;
        while (measure_done_irq !== 1'b1 && n < 1500) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic close_out();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // read data lands one edge after the strobe; oldest note is the one to match
    always @(posedge clk) begin
        if (rd_d) check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
        rd_d <= reg_rd;
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        int n;
        int s;
        int irq_n;
        logic [7:0] e;
        void'($urandom(56325));
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        random_bits = 2'($urandom_range(3, 0));
        rd(RXSED_ADDR_ENERGY, RXSED_ENERGY_RESET);
        rd(6'h3F, 8'h00);
        rd(RXSED_ADDR_LINK_QUALITY, {1'b0, random_bits, 5'h00});
        // flip crc_ok after the event so the flag must hold, not follow
        for (int c = 0; c < 2; c++) begin
            @(posedge clk);
            #1;
            crc_ok = ~c[0];
            frame_end_irq = 1'b1;
            @(posedge clk);
            #1;
            frame_end_irq = 1'b0;
            crc_ok = c[0];
            rd(RXSED_ADDR_LINK_QUALITY, {~c[0], random_bits, 5'h00});
        end
        state_listening = 1'b1;
        high_rate = 1'b1;
        // overrange raw value first, then a random legal one
        for (int i = 0; i < 2; i++) begin
            s = i ? $urandom_range(28, 1) : 31;
            strength_raw = s[4:0];
            repeat (25) @(posedge clk);
            #1;
            e = (s > 28) ? 8'h1C : 8'(s);
            check("signal_strength", {11'h000, signal_strength}, {8'h00, e});
        end
        host.access(1'b1, RXSED_ADDR_ENERGY, 8'($urandom));
        wait_done(n);
        check("manual_latency", 16'(n), 16'h0578);
        e = 8'(3 * (s - 1));
        rd(RXSED_ADDR_ENERGY, e);
        state_listening = 1'b0;
        host.access(1'b1, RXSED_ADDR_ENERGY, 8'h00);
        wait_done(n);
        // the refusal pulse already stands right after the edge that takes the write
        check("refused_latency", 16'(n), 16'h0000);
        rd(RXSED_ADDR_ENERGY, e);
        state_receiving = 1'b1;
        s = s % 28 + 1;
        strength_raw = s[4:0];
        repeat (25) @(posedge clk);
        #1;
        sync_header_found = 1'b1;
        @(posedge clk);
        #1;
        sync_header_found = 1'b0;
        irq_n = 0;
        repeat (1396) begin
            @(posedge clk);
            if (measure_done_irq !== 1'b0) irq_n++;
        end
        rd(RXSED_ADDR_ENERGY, e);
        // keep watching past the load edge, where a wrong pulse would show
        repeat (10) begin
            @(posedge clk);
            if (measure_done_irq !== 1'b0) irq_n++;
        end
        check("auto_irq", 16'(irq_n), 16'h0000);
        rd(RXSED_ADDR_ENERGY, 8'(3 * (s - 1)));
        repeat (4) @(posedge clk);
        close_out();
    end
    // watchdog: run needs about 2930 cycles
    initial begin
        #(10000 * 100);
        n_mismatch++;
        close_out();
    end
endmodule
